// file: design/cbcs_pkg.sv
// Shared types, constants and the cycle-count table of the bus cycle sequencer.
package cbcs_pkg;

    // ----------------------------------------
    // Fixed addresses and widths
    // ----------------------------------------
    localparam logic [15:0] ADDR_DEAD = 16'hffff;
    localparam logic [15:0] ADDR_VEC_HI = 16'hfffa;
    localparam logic [15:0] ADDR_VEC_LO = 16'hfffb;
    localparam logic [15:0] INT_FIRST = 16'h0000;
    localparam logic [15:0] INT_LAST = 16'h00ff;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] TWO16 = 16'h0002;
    localparam logic [3:0] STEP_ZERO = 4'h0;
    localparam logic [3:0] STEP_ONE = 4'h1;
    localparam int SYNC_W = 9;
    localparam int ADD_W = 16;

    // ----------------------------------------
    // Instruction classes and captured-byte tags
    // ----------------------------------------
    typedef enum logic [4:0] {
        cls_idx_read, cls_idx_store, cls_idx_load16, cls_idx_store16, cls_idx_rmw,
        cls_idx_test, cls_idx_cmp16, cls_idx_jump, cls_idx_jsr, cls_inh2,
        cls_inh_dead3, cls_sp_step, cls_push_acc, cls_pull_acc, cls_push_index,
        cls_pull_index, cls_ret_sub, cls_wait_int, cls_ret_int, cls_soft_int,
        cls_multiply, cls_branch, cls_branch_sub
    } cbcs_cls_e;

    typedef enum logic [3:0] {
        tag_none, tag_opcode, tag_offset, tag_next, tag_byte, tag_hi, tag_lo,
        tag_ccr, tag_acc_b, tag_acc_a, tag_idx_hi, tag_idx_lo, tag_pc_hi, tag_pc_lo,
        tag_vec_hi, tag_vec_lo
    } cbcs_tag_e;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        cbcs_cls_e cls;
        logic [15:0] pc;
        logic [15:0] idx;
        logic [15:0] sp;
        logic [7:0] offset;
        logic [7:0] acc_a;
        logic [7:0] acc_b;
        logic [7:0] ccr;
        logic [15:0] wdata;
        logic use_b;
    } cbcs_cmd_s;

    typedef struct packed {
        logic [15:0] addr;
        logic rw;
        logic [7:0] dout;
        logic doe;
    } cbcs_bus_s;

    // Bus cycles taken by each class, opcode fetch included.
    function automatic logic [3:0] cbcs_len(input cbcs_cls_e cls);
        logic [3:0] n;
        n = 4'h2;
        case (cls)
            cls_idx_jump, cls_inh_dead3, cls_sp_step, cls_push_acc, cls_branch: n = 4'h3;
            cls_idx_read, cls_idx_store, cls_pull_acc, cls_push_index: n = 4'h4;
            cls_idx_load16, cls_idx_store16, cls_pull_index, cls_ret_sub: n = 4'h5;
            cls_idx_rmw, cls_idx_test, cls_idx_cmp16, cls_idx_jsr, cls_branch_sub: n = 4'h6;
            cls_wait_int: n = 4'h9;
            cls_ret_int, cls_multiply: n = 4'ha;
            cls_soft_int: n = 4'hc;
            default: n = 4'h2;
        endcase
        return n;
    endfunction

endpackage

// file: design/cbcs_sync2.sv
// Two-stage synchroniser for pin inputs, one stage pair per bit.
`timescale 1ns/10ps
module cbcs_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ----------------------------------------
    // Per-bit flip-flop pairs
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_ff;
            logic hold_ff;
            // The first stage feeds only the second stage.
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_ff <= 1'b0;
                    hold_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[gi];
                    hold_ff <= meta_ff;
                end
            end
            assign sync_out[gi] = hold_ff;
        end
    endgenerate

endmodule

// file: design/cbcs_sum16.sv
// Sixteen-bit address adder with an unsigned or sign-extended byte offset.
`timescale 1ns/10ps
module cbcs_sum16 (
    input wire logic [15:0] base,
    input wire logic [7:0] offset,
    input wire logic sign_ext,
    output logic [15:0] sum
);

    logic [15:0] ext_offset;

    // Widens the offset and forms the full sum with carry into the high byte.
    always_comb begin
        ext_offset = {{8{sign_ext & offset[7]}}, offset};
        sum = base + ext_offset;
    end

endmodule

// file: design/cbcs_seq.sv
// Top of the bus cycle sequencer: drives address, read/write and data per E cycle.
//
// How it works
// - Internal-only cycles put FFFF on the address bus, read, data discarded.
// - Indexed: opcode, offset at PC+1, dead cycle, then access at X+offset; indexed jump ends after the dead cycle.
// - Indexed 16-bit loads/stores: high byte at X+offset, low at plus one.
// - Indexed read-modify-write: read, dead, write back; test-only ends dead instead.
// - Indexed 16-bit compares and add/subtract double end with a dead cycle.
// - Indexed call: opcode read at X+offset, return low at SP, high SP-1.
// - Two-cycle inherent ops read opcode then PC+1, nothing more.
// - Stack pointer step ops read the old stack pointer in cycle three.
// - Accumulator push writes at SP; index push writes low at SP, high SP-1.
// - Accumulator pull: discarded read at SP, then operand from SP+1.
// - Index pull: discarded read at SP, high from SP+1, low SP+2.
// - Subroutine return: discarded read at SP, high SP+1, low SP+2.
// - Wait stacks return, index, A, B and condition codes after two reads.
// - Interrupt return: discarded SP read, then SP+1 to SP+7 in order.
// - Software interrupt stacks seven bytes down from SP, then reads SP-7.
// - Software interrupt fetches the handler vector from FFFA then FFFB.
// - Branch to subroutine: offset, dead, target read, return low then high.
// - Internal location reads stay off the external data bus unless mode 0.
`timescale 1ns/10ps
module cbcs_seq (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire cbcs_pkg::cbcs_cmd_s cmd,
    input wire logic [7:0] data_in,
    input wire logic mode0_pin,
    input wire logic [7:0] int_rd_data,
    output cbcs_pkg::cbcs_bus_s bus,
    output logic busy,
    output logic done,
    output logic [3:0] cycle_num,
    output logic rd_valid,
    output cbcs_pkg::cbcs_tag_e rd_tag,
    output logic [7:0] rd_byte
);

    typedef enum logic {
        st_idle,
        st_run
    } cbcs_state_e;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    cbcs_state_e state_ff, nxt_state;
    logic [3:0] step_ff, nxt_step;
    cbcs_pkg::cbcs_cmd_s cmd_ff, nxt_cmd;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic [3:0] cyc_ff, nxt_cyc;
    cbcs_pkg::cbcs_bus_s bus_ff, nxt_bus;
    cbcs_pkg::cbcs_tag_e tag_ff, nxt_tag;
    cbcs_pkg::cbcs_tag_e tag_p1_ff, tag_p2_ff, rd_tag_ff;
    logic rd_valid_ff, mode0_sync, ext_write, int_read;
    logic [7:0] rd_byte_ff, data_sync;
    logic [7:0] echo_ff, nxt_echo;
    logic [cbcs_pkg::SYNC_W-1:0] sync_out;
    logic [15:0] ea, ea1, target, ret_long, ret_short, sp_dn, sp_up;
    logic [3:0] k, last_step;
    logic [7:0] stack_byte [0:6];

    // ----------------------------------------
    // Pin synchronisers and address adders
    // ----------------------------------------
    cbcs_sync2 #(.WIDTH(cbcs_pkg::SYNC_W)) u_sync (.clock(clock), .rst(rst),
        .async_in({mode0_pin, data_in}), .sync_out(sync_out));

    assign data_sync = sync_out[7:0];
    assign mode0_sync = sync_out[8];

    cbcs_sum16 u_ea (.base(cmd_ff.idx), .offset(cmd_ff.offset), .sign_ext(1'b0), .sum(ea));

    cbcs_sum16 u_target (.base(ret_long), .offset(cmd_ff.offset), .sign_ext(1'b1),
        .sum(target));

    // Derived addresses and stacked byte lists for the current command.
    always_comb begin
        ea1 = ea + cbcs_pkg::ONE16;
        ret_long = cmd_ff.pc + cbcs_pkg::TWO16;
        ret_short = cmd_ff.pc + cbcs_pkg::ONE16;
        k = step_ff - 4'h2;
        sp_dn = cmd_ff.sp - {12'h000, k};
        sp_up = cmd_ff.sp + {12'h000, k};
        last_step = cbcs_pkg::cbcs_len(cmd_ff.cls) - 4'h1;
        stack_byte = '{ret_short[7:0], ret_short[15:8], cmd_ff.idx[7:0], cmd_ff.idx[15:8],
            cmd_ff.acc_a, cmd_ff.acc_b, cmd_ff.ccr};
    end

    // ----------------------------------------
    // Per-cycle bus decision
    // ----------------------------------------
    // Every cycle not named below is a dead read of the all-ones address.
    always_comb begin
        nxt_bus.addr = cbcs_pkg::ADDR_DEAD;
        nxt_bus.rw = 1'b1;
        nxt_bus.dout = 8'h00;
        nxt_bus.doe = 1'b0;
        nxt_tag = cbcs_pkg::tag_none;
        if (step_ff == cbcs_pkg::STEP_ZERO) begin
            nxt_bus.addr = cmd_ff.pc;
            nxt_tag = cbcs_pkg::tag_opcode;
        end else if (step_ff == cbcs_pkg::STEP_ONE) begin
            nxt_bus.addr = ret_short;
            nxt_tag = cbcs_pkg::tag_next;
            if (cmd_ff.cls <= cbcs_pkg::cls_idx_jsr || cmd_ff.cls == cbcs_pkg::cls_branch
                || cmd_ff.cls == cbcs_pkg::cls_branch_sub) begin
                nxt_tag = cbcs_pkg::tag_offset;
            end
        end else begin
            case (cmd_ff.cls)
                cbcs_pkg::cls_idx_read, cbcs_pkg::cls_idx_store, cbcs_pkg::cls_idx_load16,
                cbcs_pkg::cls_idx_store16, cbcs_pkg::cls_idx_rmw, cbcs_pkg::cls_idx_test,
                cbcs_pkg::cls_idx_cmp16, cbcs_pkg::cls_idx_jsr: begin
                    if (step_ff == 4'h3) begin
                        nxt_bus.addr = ea;
                        if (cmd_ff.cls == cbcs_pkg::cls_idx_store) begin
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = cmd_ff.wdata[7:0];
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_store16) begin
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = cmd_ff.wdata[15:8];
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_jsr) begin
                            nxt_tag = cbcs_pkg::tag_opcode;
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_load16
                            || cmd_ff.cls == cbcs_pkg::cls_idx_cmp16) begin
                            nxt_tag = cbcs_pkg::tag_hi;
                        end else begin
                            nxt_tag = cbcs_pkg::tag_byte;
                        end
                    end else if (step_ff == 4'h4) begin
                        if (cmd_ff.cls == cbcs_pkg::cls_idx_jsr) begin
                            nxt_bus.addr = cmd_ff.sp;
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = ret_long[7:0];
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_store16) begin
                            nxt_bus.addr = ea1;
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = cmd_ff.wdata[7:0];
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_load16
                            || cmd_ff.cls == cbcs_pkg::cls_idx_cmp16) begin
                            nxt_bus.addr = ea1;
                            nxt_tag = cbcs_pkg::tag_lo;
                        end
                    end else if (step_ff == 4'h5) begin
                        if (cmd_ff.cls == cbcs_pkg::cls_idx_jsr) begin
                            nxt_bus.addr = cmd_ff.sp - cbcs_pkg::ONE16;
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = ret_long[15:8];
                        end else if (cmd_ff.cls == cbcs_pkg::cls_idx_rmw) begin
                            nxt_bus.addr = ea;
                            nxt_bus.rw = 1'b0;
                            nxt_bus.dout = cmd_ff.wdata[7:0];
                        end
                    end
                end
                cbcs_pkg::cls_sp_step: begin
                    nxt_bus.addr = cmd_ff.sp;
                end
                cbcs_pkg::cls_push_acc: begin
                    nxt_bus.addr = cmd_ff.sp;
                    nxt_bus.rw = 1'b0;
                    nxt_bus.dout = cmd_ff.use_b ? cmd_ff.acc_b : cmd_ff.acc_a;
                end
                cbcs_pkg::cls_push_index: begin
                    nxt_bus.addr = sp_dn;
                    nxt_bus.rw = 1'b0;
                    nxt_bus.dout = (k == 4'h0) ? cmd_ff.idx[7:0] : cmd_ff.idx[15:8];
                end
                cbcs_pkg::cls_pull_acc, cbcs_pkg::cls_pull_index, cbcs_pkg::cls_ret_sub,
                cbcs_pkg::cls_ret_int: begin
                    nxt_bus.addr = sp_up;
                    if (k == 4'h0) begin
                        nxt_tag = cbcs_pkg::tag_none;
                    end else if (cmd_ff.cls == cbcs_pkg::cls_pull_acc) begin
                        nxt_tag = cbcs_pkg::tag_byte;
                    end else if (cmd_ff.cls == cbcs_pkg::cls_pull_index) begin
                        nxt_tag = (k == 4'h1) ? cbcs_pkg::tag_idx_hi : cbcs_pkg::tag_idx_lo;
                    end else if (cmd_ff.cls == cbcs_pkg::cls_ret_sub) begin
                        nxt_tag = (k == 4'h1) ? cbcs_pkg::tag_pc_hi : cbcs_pkg::tag_pc_lo;
                    end else begin
                        // The pull tags follow the stack order, counting up from ccr.
                        nxt_tag = cbcs_pkg::cbcs_tag_e'(cbcs_pkg::tag_ccr + k - 4'h1);
                    end
                end
                cbcs_pkg::cls_wait_int, cbcs_pkg::cls_soft_int: begin
                    nxt_bus.addr = sp_dn;
                    if (k <= 4'h6) begin
                        nxt_bus.rw = 1'b0;
                        nxt_bus.dout = stack_byte[k[2:0]];
                    end else if (k == 4'h8) begin
                        nxt_bus.addr = cbcs_pkg::ADDR_VEC_HI;
                        nxt_tag = cbcs_pkg::tag_vec_hi;
                    end else if (k == 4'h9) begin
                        nxt_bus.addr = cbcs_pkg::ADDR_VEC_LO;
                        nxt_tag = cbcs_pkg::tag_vec_lo;
                    end
                end
                cbcs_pkg::cls_branch_sub: begin
                    if (step_ff == 4'h3) begin
                        nxt_bus.addr = target;
                        nxt_tag = cbcs_pkg::tag_opcode;
                    end else if (step_ff == 4'h4) begin
                        nxt_bus.addr = cmd_ff.sp;
                        nxt_bus.rw = 1'b0;
                        nxt_bus.dout = ret_long[7:0];
                    end else if (step_ff == 4'h5) begin
                        nxt_bus.addr = cmd_ff.sp - cbcs_pkg::ONE16;
                        nxt_bus.rw = 1'b0;
                        nxt_bus.dout = ret_long[15:8];
                    end
                end
                default: begin
                    nxt_tag = cbcs_pkg::tag_none;
                end
            endcase
        end
        ext_write = ~nxt_bus.rw;
        int_read = nxt_bus.rw && (nxt_bus.addr >= cbcs_pkg::INT_FIRST)
            && (nxt_bus.addr <= cbcs_pkg::INT_LAST);
        nxt_echo = int_rd_data;
        if (state_ff != st_run) begin
            nxt_bus.addr = cbcs_pkg::ADDR_DEAD;
            nxt_bus.rw = 1'b1;
            nxt_bus.dout = 8'h00;
            nxt_bus.doe = 1'b0;
            nxt_tag = cbcs_pkg::tag_none;
        end else if (ext_write) begin
            nxt_bus.doe = 1'b1;
        end else if (int_read && mode0_sync) begin
            nxt_bus.doe = 1'b1;
            nxt_bus.dout = echo_ff;
        end
    end

    // ----------------------------------------
    // Instruction sequencing
    // ----------------------------------------
    // Steps through the cycles of the held command, then returns to idle.
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_cmd = cmd_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_cyc = cyc_ff;
        case (state_ff)
            st_idle: begin
                if (start) begin
                    nxt_state = st_run;
                    nxt_step = cbcs_pkg::STEP_ZERO;
                    nxt_cmd = cmd;
                    nxt_busy = 1'b1;
                end
            end
            st_run: begin
                nxt_cyc = step_ff + 4'h1;
                if (step_ff == last_step) begin
                    nxt_state = st_idle;
                    nxt_step = cbcs_pkg::STEP_ZERO;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                end else begin
                    nxt_step = step_ff + 4'h1;
                end
            end
            default: begin
                nxt_state = st_idle;
            end
        endcase
    end

    // Registers the sequencing state and the bus outputs.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= st_idle;
            step_ff <= 4'h0;
            cmd_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            cyc_ff <= 4'h0;
            bus_ff <= {cbcs_pkg::ADDR_DEAD, 1'b1, 8'h00, 1'b0};
            tag_ff <= cbcs_pkg::tag_none;
            echo_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            cmd_ff <= nxt_cmd;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            cyc_ff <= nxt_cyc;
            bus_ff <= nxt_bus;
            tag_ff <= nxt_tag;
            echo_ff <= nxt_echo;
        end
    end

    // ----------------------------------------
    // Read-data capture
    // ----------------------------------------
    // Delays each tag to meet its synchronised byte; untagged reads are dropped.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tag_p1_ff <= cbcs_pkg::tag_none;
            tag_p2_ff <= cbcs_pkg::tag_none;
            rd_tag_ff <= cbcs_pkg::tag_none;
            rd_valid_ff <= 1'b0;
            rd_byte_ff <= 8'h00;
        end else begin
            tag_p1_ff <= tag_ff;
            tag_p2_ff <= tag_p1_ff;
            rd_tag_ff <= tag_p2_ff;
            rd_valid_ff <= (tag_p2_ff != cbcs_pkg::tag_none);
            rd_byte_ff <= data_sync;
        end
    end

    assign bus = bus_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign cycle_num = cyc_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_tag = rd_tag_ff;
    assign rd_byte = rd_byte_ff;

endmodule

// file: sim/cbcs_mem.sv
// External memory model answering the sequencer's bus cycles.
`timescale 1ns/10ps
module cbcs_mem (
    input wire cbcs_pkg::cbcs_bus_s bus,
    output logic [7:0] data_in
);
    // Reads return a byte made from the address; on writes the core owns the data bus.
    always_comb begin
        if (bus.rw) begin
            data_in = bus.addr[7:0] ^ {bus.addr[11:8], bus.addr[15:12]};
        end else begin
            data_in = bus.dout;
        end
    end
endmodule

// file: sim/cbcs_seq_assertions.sv
// Concurrent checks on the ports of the bus cycle sequencer.
`timescale 1ns/10ps
module cbcs_seq_assertions (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire cbcs_pkg::cbcs_cmd_s cmd,
    input wire cbcs_pkg::cbcs_bus_s bus,
    input wire logic busy,
    input wire logic done,
    input wire logic [3:0] cycle_num
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);

    // Cycle order, dead cycles and data drive, each tied to its cause.
    property p_dead;
        bus.addr == 16'hffff |-> bus.rw && !bus.doe;
    endproperty
    a_dead: assert property (p_dead) else $error("dead cycle not a quiet read");
    property p_first;
        start && !busy |-> ##2 bus.addr == $past(cmd.pc, 2) && bus.rw && cycle_num == 4'h1;
    endproperty
    a_first: assert property (p_first) else $error("opcode fetch misplaced");
    property p_next;
        $past(busy) && busy && cycle_num == 4'h1 |=> bus.addr == $past(bus.addr) + 16'h0001;
    endproperty
    a_next: assert property (p_next) else $error("second fetch not at pc plus one");
    property p_step;
        $past(busy) && busy && !done |=> cycle_num == $past(cycle_num) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("cycle number skipped");
    property p_vec;
        bus.addr == 16'hfffa && busy |=> bus.addr == 16'hfffb && bus.rw && done;
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch order wrong");
    property p_done;
        done |-> !busy ##1 (!done && bus.addr == 16'hffff && bus.rw);
    endproperty
    a_done: assert property (p_done) else $error("no idle cycle after done");
    property p_wr;
        !bus.rw |-> bus.doe;
    endproperty
    a_wr: assert property (p_wr) else $error("write without data drive");
    property p_quiet;
        bus.rw && bus.addr > 16'h00ff |-> !bus.doe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("external read drives data");
endmodule
bind cbcs_seq cbcs_seq_assertions u_chk (.clock(clock), .rst(rst), .start(start), .cmd(cmd),
    .bus(bus), .busy(busy), .done(done), .cycle_num(cycle_num));

// file: sim/cpu_bus_cycle_sequencer_test.sv
// Self-checking bench for the bus cycle sequencer.
`timescale 1ns/10ps
module cpu_bus_cycle_sequencer_test;
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic start = 1'h0;
    logic mode0_pin = 1'h0;
    logic [7:0] int_rd_data = 8'h3c;
    cbcs_pkg::cbcs_cmd_s cmd;
    cbcs_pkg::cbcs_bus_s bus;
    logic busy, done, rd_valid;
    logic [3:0] cycle_num;
    cbcs_pkg::cbcs_tag_e rd_tag;
    logic [7:0] rd_byte, data_in;
    int n_errors = 0;
    int checks = 0;
    logic [15:0] ex_a[$];
    logic ex_r[$];
    logic [7:0] ex_d[$];
    // Cycle scripts and counts in class order; gen expands each code to one bus cycle, S to seven.
    string scr[23] = '{"Fe", "Fw", "Fef", "Fhl", "FeFw", "FeFF", "FefF", "F", "FeJK", "", "F", "0",
        "A", "01", "XY", "012", "012", "S", "01234567", "SmvV", "FFFFFFFF", "F", "FTJK"};
    int len[23] = '{4, 4, 5, 5, 6, 6, 6, 3, 6, 2, 3, 3, 3, 4, 4, 5, 5, 9, 10, 12, 10, 3, 6};

    cbcs_seq u_dut (.clock(clock), .rst(rst), .start(start), .cmd(cmd), .data_in(data_in),
        .mode0_pin(mode0_pin), .int_rd_data(int_rd_data), .bus(bus), .busy(busy), .done(done),
        .cycle_num(cycle_num), .rd_valid(rd_valid), .rd_tag(rd_tag), .rd_byte(rd_byte));
    cbcs_mem u_mem (.bus(bus), .data_in(data_in));

    // Free-running clock, 50 ns period.
    initial begin
        forever #25 clock = ~clock;
    end

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'h1) begin
            n_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic put(input logic [15:0] a, input logic r, input logic [7:0] d);
        ex_a.push_back(a);
        ex_r.push_back(r);
        ex_d.push_back(d);
    endtask

    // Builds the expected bus cycles of the current command from its script.
    task automatic gen(input string s);
        logic [15:0] ea;
        logic [15:0] rt;
        logic [7:0] stk[7];
        ea = cmd.idx + {8'h00, cmd.offset};
        rt = cmd.pc + 16'h0001;
        stk = '{rt[7:0], rt[15:8], cmd.idx[7:0], cmd.idx[15:8], cmd.acc_a, cmd.acc_b, cmd.ccr};
        ex_a.delete();
        ex_r.delete();
        ex_d.delete();
        put(cmd.pc, 1'h1, 8'h00);
        put(rt, 1'h1, 8'h00);
        rt = rt + 16'h0001;
        for (int i = 0; i < s.len(); i++) begin
            case (s[i])
                "F": put(16'hffff, 1'h1, 8'h00);
                "e": put(ea, 1'h1, 8'h00);
                "f": put(ea + 16'h0001, 1'h1, 8'h00);
                "w": put(ea, 1'h0, cmd.wdata[7:0]);
                "h": put(ea, 1'h0, cmd.wdata[15:8]);
                "l": put(ea + 16'h0001, 1'h0, cmd.wdata[7:0]);
                "T": put(rt + {{8{cmd.offset[7]}}, cmd.offset}, 1'h1, 8'h00);
                "J": put(cmd.sp, 1'h0, rt[7:0]);
                "K": put(cmd.sp - 16'h0001, 1'h0, rt[15:8]);
                "A": put(cmd.sp, 1'h0, cmd.acc_a);
                "X": put(cmd.sp, 1'h0, cmd.idx[7:0]);
                "Y": put(cmd.sp - 16'h0001, 1'h0, cmd.idx[15:8]);
                "S": for (int j = 0; j < 7; j++) put(cmd.sp - 16'(j), 1'h0, stk[j]);
                "m": put(cmd.sp - 16'h0007, 1'h1, 8'h00);
                "v": put(16'hfffa, 1'h1, 8'h00);
                "V": put(16'hfffb, 1'h1, 8'h00);
                default: put(cmd.sp + 16'(s[i] - "0"), 1'h1, 8'h00);
            endcase
        end
    endtask

    // Issues one command and compares every bus cycle; poke retries start while busy.
    task automatic run(input string s, input int n, input logic poke);
        int k;
        gen(s);
        while (busy !== 1'h0) @(negedge clock);
        start = 1'h1;
        @(negedge clock);
        start = 1'h0;
        for (k = 0; k < 4 && cycle_num !== 4'h1; k++) @(negedge clock);
        for (k = 0; k < 13; k++) begin
            check(bus.addr === ex_a[k] && bus.rw === ex_r[k] && cycle_num === 4'(k + 1), "cycle");
            check(bus.doe === (!ex_r[k] || (mode0_pin && ex_a[k] <= 16'h00ff)), "drive");
            if (ex_r[k] === 1'h0) check(bus.dout === ex_d[k], "write data");
            if (ex_r[k] && bus.doe === 1'h1) check(bus.dout === int_rd_data, "echo");
            if (k == 3) check(rd_valid === 1'h1 && rd_byte === 8'(ex_a[0] ^ (ex_a[0] >> 4))
                && rd_tag === cbcs_pkg::tag_opcode, "opcode capture");
            if (done === 1'h1) break;
            start = poke && k == 1;
            @(negedge clock);
        end
        check(k + 1 == n && n == ex_a.size(), "cycle count");
        $display("test of %0d cycles done", n);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: far beyond the few hundred cycles the tests need.
    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        print_verdict();
    end

    // Reset, the class table, then the awkward cases.
    initial begin
        cmd = '{cls: cbcs_pkg::cls_inh2, pc: 16'h0200, idx: 16'h10f8, sp: 16'h01f0, offset: 8'h10,
            acc_a: 8'h11, acc_b: 8'h22, ccr: 8'h33, wdata: 16'h4455, use_b: 1'h0};
        repeat (16) @(negedge clock);
        check(bus.addr === 16'hffff && bus.rw === 1'h1 && busy === 1'h0, "reset idle");
        rst = 1'h0;
        for (int i = 0; i < 23; i++) begin
            cmd.cls = cbcs_pkg::cbcs_cls_e'(i);
            run(scr[i], len[i], 1'h0);
        end
        cmd.offset = 8'hf0;
        cmd.cls = cbcs_pkg::cls_branch_sub;
        run("FTJK", 6, 1'h0);
        cmd.cls = cbcs_pkg::cls_soft_int;
        run("SmvV", 12, 1'h1);
        cmd.sp = 16'h0040;
        mode0_pin = 1'h1;
        repeat (4) @(negedge clock);
        cmd.cls = cbcs_pkg::cls_ret_int;
        run("01234567", 10, 1'h0);
        mode0_pin = 1'h0;
        repeat (4) @(negedge clock);
        cmd.cls = cbcs_pkg::cls_pull_acc;
        run("01", 4, 1'h0);
        cmd.cls = cbcs_pkg::cls_multiply;
        start = 1'h1;
        @(negedge clock);
        start = 1'h0;
        repeat (5) @(negedge clock);
        rst = 1'h1;
        @(negedge clock);
        check(bus.addr === 16'hffff && busy === 1'h0 && done === 1'h0, "mid reset");
        rst = 1'h0;
        cmd.cls = cbcs_pkg::cls_inh2;
        run("", 2, 1'h0);
        print_verdict();
    end
endmodule
